// ---- rtl/dtcc_addr_step.sv ----
// address stepping unit: moves an address by the transfer unit size
module dtcc_addr_step #(
  parameter int AW = 32
) (
  // address in
  input  wire logic [AW-1:0] addrIn,
  input  wire logic [1:0]    stepMode,
  input  wire logic          wordSize,
  // address out
  output logic      [AW-1:0] addrOut
);

  logic [AW-1:0] unitSz;

  always_comb
  begin
    unitSz = wordSize ? AW'(2) : AW'(1);
    if (stepMode == dtcc_pkg::ADR_INC)
      addrOut = addrIn + unitSz;
    else if (stepMode == dtcc_pkg::ADR_DEC)
      addrOut = addrIn - unitSz;
    else
      addrOut = addrIn;
  end

endmodule

// ---- rtl/dtcc_irq.sv ----
// interrupt unit: sticky status, write-one-to-clear, mask, level output
module dtcc_irq #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // events and software access
  input  wire logic [W-1:0] evt,
  input  wire logic [W-1:0] clrBits,
  input  wire logic [W-1:0] maskIn,
  // state out
  output logic      [W-1:0] status,
  output logic              irq
);

  typedef struct packed {
    logic [W-1:0] stat;
  } dtcc_irq_t;

  dtcc_irq_t cur_ff;
  dtcc_irq_t nxt_cur;

  always_comb
  begin
    nxt_cur = cur_ff;
    // set wins over a clear in the same cycle
    nxt_cur.stat = (cur_ff.stat & ~clrBits) | evt;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cur_ff <= '0;
    else
      cur_ff <= nxt_cur;
  end

  assign status = cur_ff.stat;
  assign irq    = |(cur_ff.stat & maskIn);

endmodule

// ---- rtl/dtcc_pkg.sv ----
// package: register map, field layout and encodings of the transfer count control block
package dtcc_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_COUNTA = 8'h04;
  localparam logic [7:0] OFS_COUNTB = 8'h08;
  localparam logic [7:0] OFS_SRC    = 8'h0C;
  localparam logic [7:0] OFS_DST    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IMASK  = 8'h18;
  localparam logic [7:0] OFS_XCOUNT = 8'h1C;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_EN       = 0;
  localparam int CTL_MODE_LO  = 1;
  localparam int CTL_SIZE     = 3;
  localparam int CTL_INTERRUPT_SELECT_BIT    = 4;
  localparam int CTL_SRC_LO   = 5;
  localparam int CTL_DST_LO   = 7;
  localparam int CTL_RPT_DST  = 9;

  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_BLOCK  = 2'h2;

  localparam logic [1:0] ADR_FIXED = 2'h0;
  localparam logic [1:0] ADR_INC   = 2'h1;
  localparam logic [1:0] ADR_DEC   = 2'h2;

  // status bits: 0 = transfer done, 1 = end of transfer (cpu interrupt passed)
  localparam int ST_DONE = 0;
  localparam int ST_END  = 1;
  localparam int ST_W    = 2;

  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [7:0]  BYTE_ONE  = 8'h01;
  localparam logic [15:0] WORD_ONE  = 16'h0001;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_WRAP} dtcc_state_t;

endpackage

// ---- rtl/dtcc_top.sv ----
// transfer count and end-of-transfer control of the data transfer controller
// What this block does
// - in repeat and block modes count register A splits into two byte halves
// - repeat mode: upper half holds transfer count, lower half counts 1 to 256
// - block mode: upper half holds block size, lower half counts 1 to 256
// - lower half decrements each transfer; at zero reloads from upper half, forever
// - repeat mode moves exactly one byte or word per activation
// - after programmed count, repeat mode restores counter and repeat-area address
// - repeat mode completion never raises cpu interrupt while interrupt select clear
// - after transfer, count zero in normal mode or select set clears enable and interrupts cpu
// - normal mode uses source, destination and count A; count B ignored
module dtcc_top #(
  parameter int AW = 32
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          nrst,
  // register port
  input  wire logic [7:0]    regAddr,
  input  wire logic [31:0]   regWdata,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [31:0]   regRdata,
  // peripheral activation
  input  wire logic          actReq,
  output logic               actClr,
  // internal bus transfer
  output logic               busReq,
  output logic      [AW-1:0] busSrc,
  output logic      [AW-1:0] busDst,
  output logic               busWord,
  input  wire logic          busDone,
  // cpu interrupt
  output logic               cpuIrq,
  output logic               irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    dtcc_pkg::dtcc_state_t st;
    logic                  en;
    logic [1:0]            mode;
    logic                  wordSz;
    logic                  interrupt_select_bit;
    logic [1:0]            srcMode;
    logic [1:0]            dstMode;
    logic                  rptDst;
    logic [15:0]           countA;
    logic [15:0]           countB;
    logic [AW-1:0]         src;
    logic [AW-1:0]         dst;
    logic [AW-1:0]         rptBase;
    logic [1:0]            imask;
    logic [15:0]           xferCnt;
    logic                  actClr;
    logic                  cpuIrq;
    logic [31:0]           rdata;
  } dtcc_top_t;

  dtcc_top_t cur_ff;
  dtcc_top_t nxt_cur;

  logic [AW-1:0]               srcStep;
  logic [AW-1:0]               dstStep;
  logic [dtcc_pkg::ST_W-1:0]   evt;
  logic [dtcc_pkg::ST_W-1:0]   clrBits;
  logic [dtcc_pkg::ST_W-1:0]   status;

  function automatic logic [AW-1:0] wordOut(input logic [31:0] v);
    wordOut = v[AW-1:0];
  endfunction

  // ---------------------------------------------------------------
  // address stepping
  // ---------------------------------------------------------------
  dtcc_addr_step #(.AW(AW)) uSrcStep (
    .addrIn   (cur_ff.src),
    .stepMode (cur_ff.srcMode),
    .wordSize (cur_ff.wordSz),
    .addrOut  (srcStep)
  );

  dtcc_addr_step #(.AW(AW)) uDstStep (
    .addrIn   (cur_ff.dst),
    .stepMode (cur_ff.dstMode),
    .wordSize (cur_ff.wordSz),
    .addrOut  (dstStep)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cur        = cur_ff;
    nxt_cur.actClr = 1'b0;
    nxt_cur.cpuIrq = 1'b0;
    nxt_cur.rdata  = '0;
    evt            = '0;
    clrBits        = '0;

    // software writes
    if (regWr)
    begin
      if (regAddr == dtcc_pkg::OFS_CTRL)
      begin
        nxt_cur.en      = regWdata[dtcc_pkg::CTL_EN];
        nxt_cur.mode    = regWdata[dtcc_pkg::CTL_MODE_LO +: 2];
        nxt_cur.wordSz  = regWdata[dtcc_pkg::CTL_SIZE];
        nxt_cur.interrupt_select_bit   = regWdata[dtcc_pkg::CTL_INTERRUPT_SELECT_BIT];
        nxt_cur.srcMode = regWdata[dtcc_pkg::CTL_SRC_LO +: 2];
        nxt_cur.dstMode = regWdata[dtcc_pkg::CTL_DST_LO +: 2];
        nxt_cur.rptDst  = regWdata[dtcc_pkg::CTL_RPT_DST];
      end
      else if (regAddr == dtcc_pkg::OFS_COUNTA)
        nxt_cur.countA = regWdata[15:0];
      else if (regAddr == dtcc_pkg::OFS_COUNTB)
        nxt_cur.countB = regWdata[15:0];
      else if (regAddr == dtcc_pkg::OFS_SRC)
      begin
        nxt_cur.src = wordOut(regWdata);
        if (!cur_ff.rptDst)
          nxt_cur.rptBase = wordOut(regWdata);
      end
      else if (regAddr == dtcc_pkg::OFS_DST)
      begin
        nxt_cur.dst = wordOut(regWdata);
        if (cur_ff.rptDst)
          nxt_cur.rptBase = wordOut(regWdata);
      end
      else if (regAddr == dtcc_pkg::OFS_STATUS)
        clrBits = regWdata[dtcc_pkg::ST_W-1:0];
      else if (regAddr == dtcc_pkg::OFS_IMASK)
        nxt_cur.imask = regWdata[dtcc_pkg::ST_W-1:0];
    end

    // software reads; unmapped addresses read zero
    if (regRd)
    begin
      if (regAddr == dtcc_pkg::OFS_CTRL)
        nxt_cur.rdata = {22'h000000, cur_ff.rptDst, cur_ff.dstMode, cur_ff.srcMode,
                         cur_ff.interrupt_select_bit, cur_ff.wordSz, cur_ff.mode, cur_ff.en};
      else if (regAddr == dtcc_pkg::OFS_COUNTA)
        nxt_cur.rdata = {16'h0000, cur_ff.countA};
      else if (regAddr == dtcc_pkg::OFS_COUNTB)
        nxt_cur.rdata = {16'h0000, cur_ff.countB};
      else if (regAddr == dtcc_pkg::OFS_SRC)
        nxt_cur.rdata = 32'(cur_ff.src);
      else if (regAddr == dtcc_pkg::OFS_DST)
        nxt_cur.rdata = 32'(cur_ff.dst);
      else if (regAddr == dtcc_pkg::OFS_STATUS)
        nxt_cur.rdata = {30'h00000000, status};
      else if (regAddr == dtcc_pkg::OFS_IMASK)
        nxt_cur.rdata = {30'h00000000, cur_ff.imask};
      else if (regAddr == dtcc_pkg::OFS_XCOUNT)
        nxt_cur.rdata = {16'h0000, cur_ff.xferCnt};
    end

    // transfer sequencer; its updates win over a register write in the same cycle
    case (cur_ff.st)
      dtcc_pkg::ST_IDLE:
      begin
        if (actReq && cur_ff.en)
          nxt_cur.st = dtcc_pkg::ST_MOVE;
      end
      dtcc_pkg::ST_MOVE:
      begin
        // one unit, byte or word, per activation
        if (busDone)
        begin
          nxt_cur.src     = srcStep;
          nxt_cur.dst     = dstStep;
          nxt_cur.xferCnt = cur_ff.xferCnt + dtcc_pkg::WORD_ONE;
          evt[dtcc_pkg::ST_DONE] = 1'b1;
          nxt_cur.st = dtcc_pkg::ST_WRAP;
          if (cur_ff.mode == dtcc_pkg::MODE_NORMAL)
            nxt_cur.countA = cur_ff.countA - dtcc_pkg::WORD_ONE;  // count B untouched
          else
            // lower half counts alone, upper half stays
            nxt_cur.countA[7:0] = cur_ff.countA[7:0] - dtcc_pkg::BYTE_ONE;
        end
      end
      dtcc_pkg::ST_WRAP:
      begin
        nxt_cur.st = dtcc_pkg::ST_IDLE;
        if (cur_ff.mode != dtcc_pkg::MODE_NORMAL && cur_ff.countA[7:0] == dtcc_pkg::BYTE_ZERO)
        begin
          // reload from upper half; zero there means 256
          nxt_cur.countA[7:0] = cur_ff.countA[15:8];
          if (cur_ff.mode == dtcc_pkg::MODE_REPEAT)
          begin
            // restore repeat area and keep going
            if (cur_ff.rptDst)
              nxt_cur.dst = cur_ff.rptBase;
            else
              nxt_cur.src = cur_ff.rptBase;
          end
        end
        // only normal mode checks for a zero count here, so in repeat and block modes only select can end it
        if (cur_ff.interrupt_select_bit || (cur_ff.mode == dtcc_pkg::MODE_NORMAL && cur_ff.countA == dtcc_pkg::COUNT_RST))
        begin
          nxt_cur.en     = 1'b0;
          nxt_cur.cpuIrq = 1'b1;
          evt[dtcc_pkg::ST_END] = 1'b1;
        end
        else
          nxt_cur.actClr = 1'b1;
      end
      default:
        nxt_cur.st = dtcc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff    <= '0;
      cur_ff.st <= dtcc_pkg::ST_IDLE;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------------------------
  // interrupt
  // ---------------------------------------------------------------
  dtcc_irq #(.W(dtcc_pkg::ST_W)) uIrq (
    .clk     (clk),
    .nrst    (nrst),
    .evt     (evt),
    .clrBits (clrBits),
    .maskIn  (cur_ff.imask),
    .status  (status),
    .irq     (irq)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdata = cur_ff.rdata;
  assign actClr   = cur_ff.actClr;
  assign cpuIrq   = cur_ff.cpuIrq;
  assign busReq   = (cur_ff.st == dtcc_pkg::ST_MOVE);
  assign busSrc   = cur_ff.src;
  assign busDst   = cur_ff.dst;
  assign busWord  = cur_ff.wordSz;

endmodule

// ---- verif/dtcc_checker_assertions.sv ----
// checker: port timing of the transfer count control block
module dtcc_checker #(
  parameter int AW = 32
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          nrst,
  // watched ports
  input wire logic          actReq,
  input wire logic          actClr,
  input wire logic          busReq,
  input wire logic [AW-1:0] busSrc,
  input wire logic [AW-1:0] busDst,
  input wire logic          busWord,
  input wire logic          busDone,
  input wire logic          cpuIrq,
  input wire logic          regRd,
  input wire logic [31:0]   regRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_unit;
    busReq && busDone;
  endsequence
  sequence s_finish;
    !busReq ##1 (actClr ^ cpuIrq);
  endsequence
  property p_start;
    $rose(busReq) |-> $past(actReq);
  endproperty
  property p_end;
    s_unit |=> s_finish;
  endproperty
  property p_oneUnit;
    s_unit |=> !busDone && !busReq;
  endproperty
  property p_cause;
    (actClr || cpuIrq) |-> $past(busDone, 2);
  endproperty
  property p_clrPulse;
    actClr |=> !actClr;
  endproperty
  property p_irqPulse;
    cpuIrq |=> !cpuIrq;
  endproperty
  property p_hold;
    busReq && !busDone |=> $stable(busSrc) && $stable(busDst) && $stable(busWord);
  endproperty
  property p_rdIdle;
    !regRd |=> regRdata == 32'h0;
  endproperty
  a_start: assert property (p_start) else $error("bus request without activation");
  a_end: assert property (p_end) else $error("no single ending after unit");
  a_oneUnit: assert property (p_oneUnit) else $error("more than one unit");
  a_cause: assert property (p_cause) else $error("ending without transfer");
  a_clrPulse: assert property (p_clrPulse) else $error("flag clear too long");
  a_irqPulse: assert property (p_irqPulse) else $error("cpu interrupt too long");
  a_hold: assert property (p_hold) else $error("unit changed in flight");
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside read");
endmodule

bind dtcc_top dtcc_checker #(.AW(AW)) u_chk (
  .clk      (clk),
  .nrst     (nrst),
  .actReq   (actReq),
  .actClr   (actClr),
  .busReq   (busReq),
  .busSrc   (busSrc),
  .busDst   (busDst),
  .busWord  (busWord),
  .busDone  (busDone),
  .cpuIrq   (cpuIrq),
  .regRd    (regRd),
  .regRdata (regRdata)
);

// ---- verif/dtcc_far_model.sv ----
// far side: requesting peripheral and internal bus with variable latency
module dtcc_far_model (
  // bench control
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       go,
  input  wire logic [1:0] dly,
  // block side
  input  wire logic       busReq,
  input  wire logic       actClr,
  input  wire logic       cpuIrq,
  output logic            busDone,
  output logic            actReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend;
  logic [1:0] cnt;
  // request falls in the acknowledge cycle, so it is never taken twice
  assign actReq = pend & ~actClr & ~cpuIrq;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pend    <= 1'b0;
      cnt     <= 2'h0;
      busDone <= 1'b0;
    end
    else
    begin
      pend    <= go | actReq;
      busDone <= busReq & ~busDone & (cnt == dly);
      cnt     <= (busReq & ~busDone & (cnt != dly)) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule

// ---- verif/testbench.sv ----
// self-checking bench of the transfer count control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("mismatch %0t %h %h", $time, a, b); end end
  logic        clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, go = 1'b0, rdPend = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, seed = 32'h9B0FF882, er;
  logic [1:0]  dly = 2'h0, ee;
  logic        actReq, actClr, busReq, busWord, busDone, cpuIrq, irq;
  logic [15:0] busSrc, busDst, b;
  logic [31:0] cb;
  logic [32:0] eb;
  int          n_errors = 0, cmp_count = 0;
  logic [31:0] qRd[$];
  logic [32:0] qBus[$];
  logic [1:0]  qEnd[$];

  dtcc_top #(.AW(16)) uut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .actReq(actReq), .actClr(actClr), .busReq(busReq), .busSrc(busSrc),
    .busDst(busDst), .busWord(busWord), .busDone(busDone), .cpuIrq(cpuIrq), .irq(irq));
  dtcc_far_model far (.clk(clk), .nrst(nrst), .go(go), .dly(dly), .busReq(busReq), .actClr(actClr),
    .cpuIrq(cpuIrq), .busDone(busDone), .actReq(actReq));

  always #2 clk = ~clk;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qRd.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  // one activation with random bus latency; unit and ending noted first
  task automatic xfer(input logic [32:0] u, input logic [1:0] e);
    int n;
    qBus.push_back(u);
    qEnd.push_back(e);
    @(posedge clk);
    go <= 1'b1;
    dly <= 2'(xs());
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (!(actClr | cpuIrq) && n < 50);
    if (n == 50)
      n_errors++;
  endtask
  task automatic finish_test();
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // outputs are sampled before this edge's updates land
  always @(posedge clk)
  begin
    if (rdPend)
    begin
      er = qRd.pop_front();
      `CHK(regRdata, er)
    end
    rdPend = regRd;
    if (busReq && busDone)
    begin
      eb = qBus.pop_front();
      `CHK({busWord, busSrc, busDst}, eb)
    end
    if (actClr || cpuIrq)
    begin
      ee = qEnd.pop_front();
      `CHK({cpuIrq, actClr}, ee)
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h20, 32'h0);
    rd(dtcc_pkg::OFS_COUNTA, 32'h0);
    // normal mode, byte units, both addresses incrementing
    wr(dtcc_pkg::OFS_CTRL, 32'h0A1);
    b = 16'(xs());
    wr(dtcc_pkg::OFS_SRC, {16'h0, b});
    wr(dtcc_pkg::OFS_DST, 32'h200);
    cb = xs();
    wr(dtcc_pkg::OFS_COUNTB, cb);
    wr(dtcc_pkg::OFS_COUNTA, 32'h2);
    xfer({1'b0, b, 16'h0200}, 2'b01);
    xfer({1'b0, b + 16'h1, 16'h0201}, 2'b10);
    rd(dtcc_pkg::OFS_COUNTA, 32'h0);
    rd(dtcc_pkg::OFS_CTRL, 32'h0A0);
    rd(dtcc_pkg::OFS_STATUS, 32'h3);
    `CHK(irq, 1'b0)
    wr(dtcc_pkg::OFS_IMASK, 32'h2);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr(dtcc_pkg::OFS_STATUS, 32'h3);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    // repeat mode, word units, source is the repeat area
    wr(dtcc_pkg::OFS_CTRL, 32'h02B);
    wr(dtcc_pkg::OFS_SRC, 32'h300);
    wr(dtcc_pkg::OFS_DST, 32'h400);
    wr(dtcc_pkg::OFS_COUNTA, 32'h0202);
    xfer({1'b1, 16'h0300, 16'h0400}, 2'b01);
    xfer({1'b1, 16'h0302, 16'h0400}, 2'b01);
    xfer({1'b1, 16'h0300, 16'h0400}, 2'b01);
    rd(dtcc_pkg::OFS_COUNTA, 32'h0201);
    // repeat mode, byte units, destination is the repeat area
    wr(dtcc_pkg::OFS_CTRL, 32'h283);
    wr(dtcc_pkg::OFS_SRC, 32'h500);
    wr(dtcc_pkg::OFS_DST, 32'h600);
    wr(dtcc_pkg::OFS_COUNTA, 32'h0101);
    xfer({1'b0, 16'h0500, 16'h0600}, 2'b01);
    xfer({1'b0, 16'h0500, 16'h0600}, 2'b01);
    rd(dtcc_pkg::OFS_DST, 32'h0600);
    // block mode, source decrementing, select bit set
    wr(dtcc_pkg::OFS_CTRL, 32'h0D5);
    wr(dtcc_pkg::OFS_SRC, 32'h10);
    wr(dtcc_pkg::OFS_DST, 32'h20);
    wr(dtcc_pkg::OFS_COUNTA, 32'h0101);
    xfer({1'b0, 16'h0010, 16'h0020}, 2'b10);
    rd(dtcc_pkg::OFS_COUNTA, 32'h0101);
    rd(dtcc_pkg::OFS_SRC, 32'h000F);
    // eight units moved in all; count B kept apart from the transfer
    rd(dtcc_pkg::OFS_XCOUNT, 32'h8);
    rd(dtcc_pkg::OFS_COUNTB, {16'h0000, cb[15:0]});
    // enable was cleared by the ending, so a new activation must be ignored
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (8) @(negedge clk);
    `CHK(busReq, 1'b0)
    repeat (3) @(posedge clk);
    finish_test();
  end

  initial
  begin
    #20000;
    n_errors++;
    finish_test();
  end
endmodule
